// File: logic/adc_sample_out.sv
// parallel sample output stage of a pipelined converter
// assumes the quantiser result arrives on clk_sys_i; the sampling clock is an async pin
//
// Functional notes
// - a conversion starts on each rising sampling-clock edge and nothing else
// - a sample's word appears three sampling-clock cycles later, one per cycle
// - word and overrange change only after a rising edge, with the strobe falling
// - overrange flag high for out-of-range samples, low otherwise
// - 14-bit two's-complement parallel word, bit 0 least, bit 13 most significant
// - strobe falls a fixed delay after the rise, rises that delay after the fall
`timescale 1ns/100ps

module adc_sample_out #(
	parameter int SAMPLE_W   = adc_out_pkg::SAMPLE_W,
	parameter int LATENCY    = adc_out_pkg::LATENCY_CYC,
	parameter int FIFO_DEPTH = adc_out_pkg::FIFO_DEPTH,
	parameter int TDR_CYC    = adc_out_pkg::TDR_CYC
) (
	// clock and reset
	input  wire logic                clk_sys_i,
	input  wire logic                rstn_i,
	// sampling clock pin
	input  wire logic                sample_clk_i,
	// quantiser result
	input  wire logic [SAMPLE_W-1:0] conv_word_i,
	input  wire logic                conv_overrange_i,
	// parallel output pins
	output logic      [SAMPLE_W-1:0] sample_word_o,
	output logic                     overrange_flag_o,
	output logic                     sample_ready_strobe_o
);

	localparam int FW    = SAMPLE_W + 1;
	localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
	localparam int STROBE_DLY = TDR_CYC + 1;

	logic                clk_meta_q;
	logic                clk_sync_q;
	logic                clk_prev_q;
	logic                rise;
	logic                fall;
	logic [TDR_CYC-1:0]  rise_sr_q;
	logic [TDR_CYC-1:0]  fall_sr_q;
	logic                upd;
	logic                upd_fall;
	logic [SAMPLE_W-1:0] hold_word_q;
	logic                hold_ovr_q;
	logic                hold_vld_q;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [FW-1:0]       fifo_out_data;
	logic [LVL_W-1:0]    fifo_level;
	logic                pop;
	logic [SAMPLE_W-1:0] word_q;
	logic                ovr_q;
	logic                strobe_q;
	logic [2:0]          upd_cnt_q;
	logic [(LATENCY+1)*FW-1:0] ref_q;

	////////////////////////////////////////////////////////////////////////////////
	// sampling clock synchroniser and edge detect
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_meta_q <= 1'b0;
			clk_sync_q <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			clk_meta_q <= sample_clk_i;
			clk_sync_q <= clk_meta_q;
			clk_prev_q <= clk_sync_q;
		end
	end

	assign rise = clk_sync_q & ~clk_prev_q;
	assign fall = ~clk_sync_q & clk_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// fixed clock-to-strobe delay, rounded up to whole system cycles
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rise_sr_q <= '0;
			fall_sr_q <= '0;
		end else begin
			rise_sr_q <= TDR_CYC'({rise_sr_q, rise});
			fall_sr_q <= TDR_CYC'({fall_sr_q, fall});
		end
	end

	assign upd      = rise_sr_q[TDR_CYC-1];
	assign upd_fall = fall_sr_q[TDR_CYC-1];

	////////////////////////////////////////////////////////////////////////////////
	// capture: only the rising sampling edge takes a sample
	// a full fifo stalls the push; a sample still held at the next rise is replaced
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_word_q <= adc_out_pkg::WORD_RST;
			hold_ovr_q  <= adc_out_pkg::OVR_RST;
			hold_vld_q  <= 1'b0;
		end else if (rise) begin
			hold_word_q <= conv_word_i;
			hold_ovr_q  <= conv_overrange_i;
			hold_vld_q  <= 1'b1;
		end else if (fifo_in_ready) begin
			hold_vld_q  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pipeline storage; popping only once LATENCY words wait gives the latency
	assign pop = upd & (fifo_level >= LVL_W'(LATENCY));

	sample_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH),
		.LVL_W (LVL_W)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (hold_vld_q & ~rise),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({hold_ovr_q, hold_word_q}),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_out_data),
		.level_o     (fifo_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// output word and overrange, updated together with the strobe's fall
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_q <= adc_out_pkg::WORD_RST;
			ovr_q  <= adc_out_pkg::OVR_RST;
		end else if (pop && fifo_out_valid) begin
			word_q <= fifo_out_data[SAMPLE_W-1:0];
			ovr_q  <= fifo_out_data[SAMPLE_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// strobe follows the sampling clock inverted and delayed
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_q <= adc_out_pkg::STROBE_RST;
		end else if (upd) begin
			strobe_q <= 1'b0;
		end else if (upd_fall) begin
			strobe_q <= 1'b1;
		end
	end

	assign sample_word_o         = word_q;
	assign overrange_flag_o      = ovr_q;
	assign sample_ready_strobe_o = strobe_q;

	////////////////////////////////////////////////////////////////////////////////
	// assertion helper: delayed rises seen since reset, saturating
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			upd_cnt_q <= 3'h0;
		end else if (upd && upd_cnt_q != 3'h7) begin
			upd_cnt_q <= upd_cnt_q + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertion helper: samples of the last rises, kept apart from the fifo
	// so the latency check does not lean on the logic that it checks
	always_ff @(posedge clk_sys_i) begin
		if (rise) begin
			ref_q <= {ref_q[LATENCY*FW-1:0], conv_overrange_i, conv_word_i};
		end
	end

	AST_CAPTURE_ON_RISE: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(hold_vld_q && !$past(hold_vld_q)) |-> $past(rise)
	) else $error("sample captured without a rising sampling edge");

	AST_RISE_CAPTURES: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rise |=> (hold_vld_q && hold_word_q == $past(conv_word_i))
	) else $error("rising sampling edge did not capture the sample");

	AST_NO_LOST_SAMPLE: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rise |-> !hold_vld_q
	) else $error("sample still waiting when the next conversion started");

	AST_WORD_EVERY_CYCLE: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(upd && upd_cnt_q >= 3'(LATENCY)) |-> pop
	) else $error("primed pipeline skipped an output word");

	AST_LATENCY_PRIMED: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(upd && upd_cnt_q < 3'(LATENCY)) |=> $stable(word_q) && $stable(ovr_q)
	) else $error("output word before the pipeline latency elapsed");

	AST_CHANGE_WITH_STROBE: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		($changed(word_q) || $changed(ovr_q)) |-> $fell(strobe_q)
	) else $error("output changed without a strobe fall");

	AST_OVR_FROM_FIFO: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(upd && upd_cnt_q >= 3'(LATENCY)) |=> ovr_q == $past(ref_q[LATENCY*FW+SAMPLE_W])
	) else $error("overrange flag does not follow its sample");

	AST_WORD_FROM_FIFO: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(upd && upd_cnt_q >= 3'(LATENCY)) |=> word_q == $past(ref_q[LATENCY*FW +: SAMPLE_W])
	) else $error("output word does not match its sample");

	AST_STROBE_FALL_DELAY: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		rise |-> ##STROBE_DLY !strobe_q
	) else $error("strobe did not fall a fixed delay after the rise");

	AST_STROBE_RISE_DELAY: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(strobe_q) |-> $past(fall, STROBE_DLY)
	) else $error("strobe rose without a delayed sampling-clock fall");

endmodule

// File: logic/adc_out_pkg.sv
// constants shared by the sample output path of the converter
// assumes a 250 MHz system clock that oversamples the sampling clock pin
package adc_out_pkg;

	// output word
	localparam int SAMPLE_W      = 14;
	localparam int LATENCY_CYC   = 3;
	localparam int FIFO_DEPTH    = 4;

	// timing
	localparam int CLK_SYS_PS    = 4000;
	localparam int TDR_MIN_PS    = 2800;
	localparam int TDR_CYC_RAW   = (TDR_MIN_PS + CLK_SYS_PS - 1) / CLK_SYS_PS;
	localparam int TDR_CYC       = (TDR_CYC_RAW < 1) ? 1 : TDR_CYC_RAW;

	// reset values
	localparam logic [SAMPLE_W-1:0] WORD_RST   = 14'h0000;
	localparam logic                OVR_RST    = 1'b0;
	localparam logic                STROBE_RST = 1'b1;

endpackage

// File: logic/sample_fifo.sv
// small synchronous fifo holding converted samples between capture and output
// assumes one clock and one asynchronous active-low reset
`timescale 1ns/100ps

module sample_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 4,
	parameter int LVL_W = $clog2(DEPTH + 1)
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rstn_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o,
	// fill level
	output logic      [LVL_W-1:0] level_o
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [LVL_W-1:0] level_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (level_q != LVL_W'(DEPTH));
	assign out_valid_o = (level_q != '0);
	assign out_data_o  = mem_q[rd_ptr_q];
	assign level_o     = level_q;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	////////////////////////////////////////////////////////////////////////////////
	// storage: no reset, contents only matter while counted
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pointers and level
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				level_q <= level_q + 1'b1;
			end else if (pop && !push) begin
				level_q <= level_q - 1'b1;
			end
		end
	end

endmodule

// File: sim/sample_receiver.sv
// receiving logic model: latches each word and flag on the strobe's rising edge
// assumes strobe, word and flag come straight from the converter output pins
`timescale 1ns/100ps

module sample_receiver (
	// observing clock and reset
	input  wire logic                             clk_sys_i,
	input  wire logic                             rstn_i,
	// converter output pins
	input  wire logic                             strobe_i,
	input  wire logic [adc_out_pkg::SAMPLE_W-1:0] word_i,
	input  wire logic                             ovr_i,
	// latched result and counts
	output logic      [adc_out_pkg::SAMPLE_W:0]   got_o,
	output logic      [15:0]                      latch_cnt_o,
	output logic      [15:0]                      bad_cnt_o
);
	logic [adc_out_pkg::SAMPLE_W:0] prev_q;
	logic                           strobe_q;

	initial begin
		got_o = '0;
		latch_cnt_o = '0;
		bad_cnt_o = '0;
		prev_q = '0;
		strobe_q = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// latch on the rise: word and flag are settled midway between updates
	// counted only out of reset: the strobe's reset level makes an edge at start-up
	always @(posedge strobe_i) begin
		if (rstn_i === 1'b1) begin
			got_o <= {ovr_i, word_i};
			latch_cnt_o <= latch_cnt_o + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// a change without a strobe fall in the same cycle would corrupt a latch
	always @(posedge clk_sys_i) begin
		if (rstn_i === 1'b1 && {ovr_i, word_i} !== prev_q &&
			!(strobe_q === 1'b1 && strobe_i === 1'b0)) begin
			bad_cnt_o <= bad_cnt_o + 16'h0001;
		end
		prev_q <= {ovr_i, word_i};
		strobe_q <= strobe_i;
	end
endmodule

// File: sim/test_adc_sample_out.sv
// testbench for the converter's parallel sample output stage
// assumes the receiver model in sample_receiver.sv; sampling pin driven on clk_sys_i edges
`timescale 1ns/100ps

module test_adc_sample_out;
	logic        clk_sys_i;
	logic        rstn_i;
	logic        sample_clk_i;
	logic [13:0] conv_word_i;
	logic        conv_overrange_i;
	logic [13:0] sample_word_o;
	logic        overrange_flag_o;
	logic        sample_ready_strobe_o;
	logic [14:0] got;
	logic [15:0] latch_cnt;
	logic [15:0] bad_cnt;
	logic [14:0] exp_q[$];
	int          miscompares;
	int          samples_checked;
	int          period_n;

	adc_sample_out i_adc_sample_out (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.sample_clk_i(sample_clk_i), .conv_word_i(conv_word_i),
		.conv_overrange_i(conv_overrange_i), .sample_word_o(sample_word_o),
		.overrange_flag_o(overrange_flag_o), .sample_ready_strobe_o(sample_ready_strobe_o));
	sample_receiver i_sample_receiver (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.strobe_i(sample_ready_strobe_o), .word_i(sample_word_o), .ovr_i(overrange_flag_o),
		.got_o(got), .latch_cnt_o(latch_cnt), .bad_cnt_o(bad_cnt));

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one sampling period of 31 or 32 cycles: 16 high, the rest low; 125 ns on average
	task automatic send(input logic [13:0] w, input logic o);
		logic [15:0] cnt0;
		logic [14:0] exp;
		cnt0 = latch_cnt;
		exp_q.push_back({o, w});
		@(posedge clk_sys_i);
		sample_clk_i <= 1'b1;
		conv_word_i <= w;
		conv_overrange_i <= o;
		repeat (16) @(posedge clk_sys_i);
		sample_clk_i <= 1'b0;
		repeat ((period_n % 4 == 3) ? 15 : 14) @(posedge clk_sys_i);
		period_n++;
		// nothing leaves the pipeline until three samples wait behind it
		exp = (exp_q.size() > 3) ? exp_q.pop_front() : 15'h0000;
		check("latched word", {1'b0, exp}, {1'b0, got});
		check("strobe rises per period", 16'h0001, latch_cnt - cnt0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_stream;
		logic [13:0] pat[8] = '{14'h2000, 14'h1FFF, 14'h0000, 14'h3FFF,
			14'h0001, 14'h2AAA, 14'h1555, 14'h3FFE};
		for (int i = 0; i < 8; i++) send(pat[i], i[0]);
		check("early updates", 16'h0000, bad_cnt);
		$display("test_stream done");
	endtask

	// pin held low while the quantiser result moves: no conversion may start
	task automatic test_idle;
		logic [15:0] cnt0;
		logic [14:0] out0;
		cnt0 = latch_cnt;
		out0 = {overrange_flag_o, sample_word_o};
		for (int i = 0; i < 100; i++) begin
			@(posedge clk_sys_i);
			conv_word_i <= 14'(i * 163);
			conv_overrange_i <= i[1];
		end
		repeat (4) @(posedge clk_sys_i);
		check("idle latches", cnt0, latch_cnt);
		check("idle output", {1'b0, out0}, {1'b0, overrange_flag_o, sample_word_o});
		check("idle strobe", 16'h0001, {15'h0000, sample_ready_strobe_o});
		for (int i = 0; i < 4; i++) send(14'h0ABC + 14'(i), ~i[0]);
		$display("test_idle done");
	endtask

	task automatic do_reset;
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		check("reset outputs", 16'h0001, {overrange_flag_o, sample_word_o, sample_ready_strobe_o});
		rstn_i <= 1'b1;
		exp_q.delete();
		repeat (4) @(posedge clk_sys_i);
	endtask

	task automatic test_rerun;
		do_reset();
		for (int i = 0; i < 5; i++) send(14'h3000 - 14'(i), i == 4);
		check("early updates", 16'h0000, bad_cnt);
		$display("test_rerun done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		miscompares = 0;
		samples_checked = 0;
		period_n = 0;
		rstn_i = 1'b0;
		sample_clk_i = 1'b0;
		conv_word_i = 14'h0000;
		conv_overrange_i = 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		test_stream();
		test_idle();
		test_rerun();
		end_sim();
	end
endmodule
